// File: core/pst_timer.sv
`timescale 1ns/100ps
module pst_timer
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire pst_pkg::pst_apb_req_t apb_req,
    output      pst_pkg::pst_apb_rsp_t apb_rsp,
    input  wire logic                 ext_count_pin,
    input  wire logic                 ext_int_pin,
    input  wire logic                 ovf_vector_ack,
    output      logic                 irq
);
    import pst_pkg::*;

    localparam int EXT_LO = DLY_MIN_CYC - SYNC_STAGES;
    localparam int EXT_HI = DLY_MAX_CYC - SYNC_STAGES;

    pst_state_t r;
    pst_state_t next_r;

    logic            setup_ph;
    logic            access_ph;
    logic            wr_en;
    logic            hit;
    logic            wr_ctrl;
    logic            wr_lo;
    logic            wr_hi;
    logic            instr_en;
    logic            half_en;
    logic            src_int;
    logic            cnt_edge;
    logic            int_edge;
    logic            src_tick;
    logic            pre_tick;
    logic [7:0]      pre_mask;
    logic            inc;
    logic            lo_inc;
    logic            hi_inc;
    logic            ovf_evt;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    logic [7:0]      rd_byte;

    ////////////////////////////////////////////////////////////////////////////////////////
    // division ratio as a low-bit mask of the prescaler
    function automatic logic [7:0] ratio_mask(input logic [3:0] code);
        logic [7:0] m;
        m = 8'h00;
        if (code[3])
        begin
            m = BYTE_MAX;
        end
        else
        begin
            m = 8'((9'h001 << code[2:0]) - 9'h001);
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r    = r;
        setup_ph  = apb_req.psel & ~apb_req.penable;
        access_ph = apb_req.psel & apb_req.penable;
        wr_en     = access_ph & apb_req.pwrite & apb_req.pstrb[0];
        hit       = (apb_req.paddr == CTRL_ADDR) | (apb_req.paddr == CNT_LO_ADDR)
                  | (apb_req.paddr == CNT_HI_ADDR) | (apb_req.paddr == STAT_ADDR)
                  | (apb_req.paddr == MASK_ADDR);
        wr_ctrl   = wr_en & (apb_req.paddr == CTRL_ADDR);
        wr_lo     = wr_en & (apb_req.paddr == CNT_LO_ADDR);
        wr_hi     = wr_en & (apb_req.paddr == CNT_HI_ADDR);

        // instruction clock is a quarter of pclk; prescaler output sampled every half
        instr_en  = (r.div == 2'(INSTR_DIV - 1));
        half_en   = r.div[0];
        next_r.div = r.div + 2'h1;

        // only the second and third stages are looked at
        next_r.cnt_sync = {r.cnt_sync[1:0], ext_count_pin};
        next_r.int_sync = {r.int_sync[1:0], ext_int_pin};
        src_int  = r.ctrl[COUNT_SRC_BIT];
        cnt_edge = r.ctrl[COUNT_EDGE_BIT] ? (r.cnt_sync[1] & ~r.cnt_sync[2])
                                          : (~r.cnt_sync[1] & r.cnt_sync[2]);
        int_edge = r.ctrl[EXT_INT_EDGE_BIT] ? (r.int_sync[1] & ~r.int_sync[2])
                                            : (~r.int_sync[1] & r.int_sync[2]);

        src_tick = src_int ? instr_en : cnt_edge;
        pre_mask = ratio_mask(r.ctrl[PS_MSB:PS_LSB]);
        pre_tick = src_tick & ((r.pre & pre_mask) == pre_mask);

        // external path: prescaled events toggle psout, resampled on the pclk phases
        if (!src_int && pre_tick)
        begin
            next_r.psout = ~r.psout;
        end
        if (half_en)
        begin
            next_r.ps_samp = r.psout;
        end
        inc = src_int ? pre_tick : (half_en & (r.psout != r.ps_samp));

        if (wr_lo | wr_hi)
        begin
            next_r.pre = BYTE_ZERO;
        end
        else if (src_tick)
        begin
            next_r.pre = r.pre + 8'h01;
        end

        // a write blocks its own byte for one instruction cycle; a low-byte write also blocks the carry into the high byte
        lo_inc  = inc & ~r.blk_lo & ~wr_lo;
        hi_inc  = lo_inc & (r.cnt_lo == BYTE_MAX) & ~r.blk_hi & ~wr_hi;
        ovf_evt = hi_inc & (r.cnt_hi == BYTE_MAX);
        next_r.blk_lo = wr_lo | (r.blk_lo & ~instr_en);
        next_r.blk_hi = wr_hi | (r.blk_hi & ~instr_en);

        if (wr_lo)
        begin
            next_r.cnt_lo = apb_req.pwdata[7:0];
        end
        else if (lo_inc)
        begin
            next_r.cnt_lo = r.cnt_lo + 8'h01;
        end
        if (wr_hi)
        begin
            next_r.cnt_hi = apb_req.pwdata[7:0];
        end
        else if (hi_inc)
        begin
            next_r.cnt_hi = r.cnt_hi + 8'h01;
        end

        if (wr_ctrl)
        begin
            next_r.ctrl = apb_req.pwdata[7:0] & CTRL_WMASK;
        end

        // sticky flags: a set in the same cycle as a clear wins
        st_set         = '0;
        st_set[ST_OVF] = ovf_evt;
        st_set[ST_PIN] = ~src_int & cnt_edge;
        st_set[ST_INT] = int_edge;
        st_clr         = '0;
        if (wr_en && apb_req.paddr == STAT_ADDR)
        begin
            st_clr = apb_req.pwdata[ST_W-1:0];
        end
        st_clr[ST_OVF] = st_clr[ST_OVF] | ovf_vector_ack;
        next_r.status  = (r.status & ~st_clr) | st_set;
        if (wr_en && apb_req.paddr == MASK_ADDR)
        begin
            next_r.mask = apb_req.pwdata[ST_W-1:0];
        end

        case (apb_req.paddr)
            CTRL_ADDR:   rd_byte = r.ctrl & CTRL_WMASK;
            CNT_LO_ADDR: rd_byte = r.cnt_lo;
            CNT_HI_ADDR: rd_byte = r.cnt_hi;
            STAT_ADDR:   rd_byte = 8'(r.status);
            MASK_ADDR:   rd_byte = 8'(r.mask);
            default:     rd_byte = BYTE_ZERO;
        endcase
        if (setup_ph && !apb_req.pwrite)
        begin
            next_r.rdata = 32'(rd_byte);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= STATE_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // zero wait states: read data is captured in the setup cycle
    assign apb_rsp.prdata  = r.rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_ph & ~hit;
    // the flag still sets while masked; only the pin is gated
    assign irq = |(r.status & r.mask);

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence ext_pin_evt;
        !src_int && r.ctrl[PS_MSB:PS_LSB] == 4'h0 && cnt_edge && !r.blk_lo;
    endsequence

    sequence lo_step;
        lo_inc ##1 !r.blk_lo;
    endsequence

    ctrl_bit0_zero_a: assert property (r.ctrl[0] == 1'b0 && !r.ctrl[0])
        else $error("control bit 0 is not zero");

    ovf_flag_set_a: assert property (ovf_evt |=> r.status[ST_OVF] && r.cnt_hi == BYTE_ZERO)
        else $error("overflow did not set flag");

    wrap_zero_a: assert property (hi_inc && r.cnt_hi == BYTE_MAX |=> {r.cnt_hi, r.cnt_lo} == 16'h0)
        else $error("counter did not wrap to zero");

    carry_high_a: assert property (hi_inc |=> r.cnt_hi == $past(r.cnt_hi) + 8'h01)
        else $error("low wrap did not carry into high byte");

    masked_irq_a: assert property (!r.mask[ST_OVF] && r.status == 3'h1 |-> !irq)
        else $error("masked overflow raised irq");

    vector_clear_a: assert property (ovf_vector_ack && !ovf_evt |=> !r.status[ST_OVF])
        else $error("vector did not clear overflow flag");

    write_block_a: assert property (wr_lo && !wr_hi |=> r.pre == BYTE_ZERO && r.blk_lo && !r.blk_hi)
        else $error("counter write did not clear prescaler or block");

    internal_rate_a: assert property
        (src_int && r.ctrl[PS_MSB:PS_LSB] == 4'h0 && !r.blk_lo && !wr_lo |-> lo_inc == instr_en)
        else $error("internal 1:1 rate wrong");

    ps256_tick_a: assert property (pre_tick && r.ctrl[PS_MSB] |-> r.pre == BYTE_MAX)
        else $error("1:256 prescaler ticked early");

    ext_delay_a: assert property (ext_pin_evt |-> ##[EXT_LO:EXT_HI] lo_inc)
        else $error("pin edge not counted in time");

    pin_flag_a: assert property (!src_int && cnt_edge |=> r.status[ST_PIN])
        else $error("pin edge flag not set");

    int_edge_a: assert property (int_edge |=> r.status[ST_INT])
        else $error("interrupt pin edge flag not set");

    lo_step_a: assert property (lo_step |-> r.cnt_lo == $past(r.cnt_lo) + 8'h01)
        else $error("low byte did not step");

endmodule

// File: core/pst_pkg.sv
package pst_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed
    {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } pst_apb_req_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } pst_apb_rsp_t;

    ////////////////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] CTRL_IDX   = 8'h05;
    localparam logic [ADDR_W-1:0] CNT_LO_IDX = 8'h0b;
    localparam logic [ADDR_W-1:0] CNT_HI_IDX = 8'h0c;
    localparam logic [ADDR_W-1:0] STAT_IDX   = 8'h10;
    localparam logic [ADDR_W-1:0] MASK_IDX   = 8'h11;
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = ADDR_W'(CTRL_IDX * 4);
    localparam logic [ADDR_W-1:0] CNT_LO_ADDR = ADDR_W'(CNT_LO_IDX * 4);
    localparam logic [ADDR_W-1:0] CNT_HI_ADDR = ADDR_W'(CNT_HI_IDX * 4);
    localparam logic [ADDR_W-1:0] STAT_ADDR   = ADDR_W'(STAT_IDX * 4);
    localparam logic [ADDR_W-1:0] MASK_ADDR   = ADDR_W'(MASK_IDX * 4);

    // control fields
    localparam int         EXT_INT_EDGE_BIT = 7;
    localparam int         COUNT_EDGE_BIT   = 6;
    localparam int         COUNT_SRC_BIT    = 5;
    localparam int         PS_MSB           = 4;
    localparam int         PS_LSB           = 1;
    localparam logic [7:0] CTRL_WMASK       = 8'hfe;
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam logic [7:0] BYTE_MAX         = 8'hff;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;

    // status and mask layout
    localparam int         ST_W   = 3;
    localparam int         ST_OVF = 0;
    localparam int         ST_PIN = 1;
    localparam int         ST_INT = 2;
    localparam logic [2:0] ST_RESET = 3'h0;

    // timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int TOSC_NS       = CLK_PERIOD_NS;
    localparam int INSTR_DIV     = 4;
    localparam int DLY_MIN_TOSC  = 3;
    localparam int DLY_MAX_TOSC  = 7;
    localparam int DLY_MIN_CYC   = (DLY_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_MAX_CYC   = (DLY_MAX_TOSC * TOSC_NS) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;

    typedef struct packed
    {
        logic [7:0]      ctrl;
        logic [7:0]      cnt_lo;
        logic [7:0]      cnt_hi;
        logic [7:0]      pre;
        logic            psout;
        logic            ps_samp;
        logic            blk_lo;
        logic            blk_hi;
        logic [1:0]      div;
        logic [2:0]      cnt_sync;
        logic [2:0]      int_sync;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [31:0]     rdata;
    } pst_state_t;

    localparam pst_state_t STATE_RESET = '0;

endpackage

// File: bench/pst_pin_src.sv
`timescale 1ns/100ps
module pst_pin_src
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [7:0] high_cyc,
    input  wire logic [7:0] low_cyc,
    output      logic       pin,
    output      logic       busy
);
    logic [8:0] left;

    // one whole pulse per request; both levels last whole cycles so the sampler sees them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin  <= 1'b0;
            left <= '0;
        end
        else if (go && left == 9'h0)
        begin
            pin  <= 1'b1;
            left <= 9'(high_cyc) + 9'(low_cyc);
        end
        else if (left != 9'h0)
        begin
            left <= left - 9'h1;
            if (left == 9'(low_cyc))
            begin
                pin <= 1'b0;
            end
        end
    end

    assign busy = left != 9'h0;
endmodule

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
    import pst_pkg::*;
    logic         pclk    = 1'b0;
    logic         presetn = 1'b0;
    pst_apb_req_t req     = '0;
    pst_apb_rsp_t rsp;
    logic         int_pin = 1'b0;
    logic         ack     = 1'b0;
    logic         go      = 1'b0;
    logic [7:0]   hi_c    = 8'h1e;
    logic [7:0]   lo_c    = 8'h1e;
    logic         irq;
    logic         pin;
    logic         busy;
    logic [31:0]  rd;
    logic         err;
    logic [31:0]  rng     = 32'h0000798c;
    logic [3:0]   strb    = 4'hf;
    logic [7:0]   ra [5]  = '{CTRL_ADDR, CNT_LO_ADDR, CNT_HI_ADDR, STAT_ADDR, MASK_ADDR};
    int           errors  = 0;
    int           checks  = 0;
    int           n;

    always #25 pclk = ~pclk;

    pst_timer dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .ext_count_pin(pin), .ext_int_pin(int_pin), .ovf_vector_ack(ack), .irq(irq));
    pst_pin_src src_u (.pclk(pclk), .presetn(presetn), .go(go), .high_cyc(hi_c),
        .low_cyc(lo_c), .pin(pin), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic int ratio(int c);
        return (c > 7) ? 256 : (1 << c);
    endfunction

    task automatic wait_n(int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic chk(logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        req.pstrb   <= strb;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rdchk(logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic start_pulse();
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    task automatic end_pulse();
        do @(posedge pclk); while (busy);
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        wait_n(12);
        presetn <= 1'b1;
        foreach (ra[i]) rdchk(ra[i], 32'h0);
        apb(1'b0, 8'h80, 32'hffffffff);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        repeat (4)
        begin
            n = int'(xs());
            apb(1'b1, CTRL_ADDR, 32'(n));
            rdchk(CTRL_ADDR, 32'(n) & 32'h000000fe);
        end
        // a reset mid-run must drop whatever the last control write left
        apb(1'b1, CTRL_ADDR, 32'hfe);
        presetn <= 1'b0;
        wait_n(2);
        presetn <= 1'b1;
        rdchk(CTRL_ADDR, 32'h0);
        // a write without the low byte strobe must leave the register alone
        strb = 4'he;
        apb(1'b1, CTRL_ADDR, 32'hfe);
        strb = 4'hf;
        rdchk(CTRL_ADDR, 32'h0);
        // internal source, every prescale code; the byte write clears the prescaler
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, CTRL_ADDR, 32'h20 | 32'(c << 1));
            apb(1'b1, CNT_LO_ADDR, 32'h0);
            wait_n(20 * ratio(c) + 2 * ratio(c));
            apb(1'b0, CNT_LO_ADDR, 32'h0);
            chk({31'h0, rd >= 4 && rd <= 6}, 32'h1);
        end
        // internal source at 1:1; at 1:4 or slower the wrap would not land inside the wait
        apb(1'b1, CTRL_ADDR, 32'h20);
        apb(1'b1, MASK_ADDR, 32'h0);
        apb(1'b1, STAT_ADDR, 32'h7);
        apb(1'b1, CNT_LO_ADDR, 32'hfd);
        apb(1'b1, CNT_HI_ADDR, 32'hff);
        wait_n(40);
        rdchk(CNT_HI_ADDR, 32'h0);
        rdchk(STAT_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, MASK_ADDR, 32'h1);
        // irq follows the mask flop, so look once it has settled
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        wait_n(2);
        rdchk(STAT_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // external source, both counting edges; read launched soon after the rise
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, CTRL_ADDR, 32'(e << 6));
            apb(1'b1, CNT_LO_ADDR, 32'h0);
            apb(1'b1, STAT_ADDR, 32'h7);
            start_pulse();
            wait_n(5);
            rdchk(CNT_LO_ADDR, 32'(e));
            end_pulse();
            wait_n(10);
            rdchk(CNT_LO_ADDR, 32'h1);
            rdchk(STAT_ADDR, 32'h2);
        end
        // random pulse train through the 1:2 prescaler
        apb(1'b1, CTRL_ADDR, 32'h42);
        apb(1'b1, CNT_LO_ADDR, 32'h0);
        n = 2 + int'(xs() % 8);
        repeat (n)
        begin
            hi_c <= 8'(4 + xs() % 8);
            lo_c <= 8'(4 + xs() % 8);
            start_pulse();
            end_pulse();
        end
        wait_n(10);
        rdchk(CNT_LO_ADDR, 32'(n / 2));
        apb(1'b1, MASK_ADDR, 32'h4);
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, CTRL_ADDR, 32'(e << 7));
            apb(1'b1, STAT_ADDR, 32'h7);
            int_pin <= 1'b1;
            wait_n(6);
            rdchk(STAT_ADDR, 32'(e << 2));
            chk({31'h0, irq}, 32'(e));
            int_pin <= 1'b0;
            wait_n(6);
            rdchk(STAT_ADDR, 32'h4);
            apb(1'b1, STAT_ADDR, 32'h4);
            rdchk(STAT_ADDR, 32'h0);
        end
        give_verdict();
    end

    // the sequence needs roughly 51000 cycles
    initial
    begin
        wait_n(90000);
        errors++;
        give_verdict();
    end
endmodule
